// [logic/iosc_top.sv]
`timescale 1ns/1ps
// Behaviour
// - Eight direct inputs, each with selectable function
// - Direct input inversion swaps ON/OFF sense
// - Direct input ON dead-time 0 to 250 ms
// - Direct one-shot drops input after 250 us
// - Each direct input also drives composite function
// - Four virtual inputs, each with selectable function
// - Virtual input triggered by selected output signal
// - Virtual input inversion swaps ON/OFF sense
// - Virtual input ON dead-time 0 to 250 ms
// - Virtual input one-shot enable, default off
// - Eight direct outputs, each with selectable function
// - ON only after level outlasts dead-time
// - Virtual input follows its source signal
// - Virtual one-shot drops after 250 us
module iosc_top import iosc_pkg::*; (
   // Clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // Register bus
   input  wire iosc_axil_req_t    axil_req,
   output iosc_axil_rsp_t         axil_rsp,
   // Input terminals
   input  wire logic [N_DIN-1:0]  din_raw,
   // Internal output signal list
   input  wire logic [N_SIG-1:0]  out_sig,
   // Conditioned input function list
   output logic [N_SIG-1:0]       in_func,
   // Output terminals
   output logic [N_DOUT-1:0]      dout
);

   localparam int IDX_W = ADDR_W - 2;

   typedef struct packed {
      logic [N_CFG-1:0][DATA_W-1:0] cfg;
      logic                         aw_held;
      logic [ADDR_W-1:0]            awaddr;
      logic                         w_held;
      logic [DATA_W-1:0]            wdata;
      logic [STRB_W-1:0]            wstrb;
      iosc_axil_rsp_t               rsp;
      logic [N_DOUT-1:0]            dout;
      logic [N_SIG-1:0]             in_func;
   } iosc_top_state_t;

   localparam logic [N_CFG-1:0][DATA_W-1:0] CFG_RST = {
      RST_DOUT_FUNC1, RST_DOUT_FUNC0, RST_NONE, RST_NONE, RST_NONE,
      RST_NONE, RST_NONE, RST_NONE, RST_DIN_FUNC1, RST_DIN_FUNC0};

   localparam logic [IDX_W-1:0] I_DIN_FUNC0  = OFS_DIN_FUNC0[ADDR_W-1:2];
   localparam logic [IDX_W-1:0] I_DIN_COMP0  = OFS_DIN_COMP0[ADDR_W-1:2];
   localparam logic [IDX_W-1:0] I_DIN_CFG    = OFS_DIN_CFG[ADDR_W-1:2];
   localparam logic [IDX_W-1:0] I_VIN_FUNC   = OFS_VIN_FUNC[ADDR_W-1:2];
   localparam logic [IDX_W-1:0] I_VIN_SRC    = OFS_VIN_SRC[ADDR_W-1:2];
   localparam logic [IDX_W-1:0] I_VIN_CFG    = OFS_VIN_CFG[ADDR_W-1:2];
   localparam logic [IDX_W-1:0] I_DOUT_FUNC0 = OFS_DOUT_FUNC0[ADDR_W-1:2];
   localparam logic [IDX_W-1:0] I_STATUS     = OFS_STATUS[ADDR_W-1:2];
   localparam logic [IDX_W-1:0] I_INFUNC_LO  = OFS_INFUNC_LO[ADDR_W-1:2];
   localparam logic [IDX_W-1:0] I_INFUNC_HI  = OFS_INFUNC_HI[ADDR_W-1:2];

   iosc_top_state_t   st_reg;
   iosc_top_state_t   st_next;
   logic              tick;
   logic [N_CHAN-1:0] chan_raw;
   logic [N_CHAN-1:0] chan_on;

   // Code held in lane n of a packed group of four-lane words
   function automatic logic [CODE_W-1:0] code_at(
      input logic [N_CFG-1:0][DATA_W-1:0] cfg,
      input logic [IDX_W-1:0]             base,
      input int                           n);
      logic [IDX_W-1:0] idx;
      idx     = base + IDX_W'(n / STRB_W);
      code_at = cfg[idx][(n % STRB_W) * LANE_W +: CODE_W];
   endfunction

   // Dead time clamped to the documented range
   function automatic logic [DEAD_W-1:0] clamp_dead(input logic [DEAD_W-1:0] v);
      clamp_dead = (v > DEAD_W'(DEAD_MAX_MS)) ? DEAD_W'(DEAD_MAX_MS) : v;
   endfunction

   // Signal from the output list; code 0 reads as constant low
   function automatic logic sig_at(input logic [N_SIG-1:0] s, input logic [CODE_W-1:0] c);
      sig_at = (c == CODE_W'(OUT_ALWAYS_LOW_SOURCE)) ? 1'b0 : s[c];
   endfunction

   iosc_tick #(
      .CYC     (TICK_CYC)
   ) u_tick (
      .aclk    (aclk),
      .aresetn (aresetn),
      .tick    (tick)
   );

   // One conditioner per direct and virtual input
   for (genvar g = 0; g < N_CHAN; g++) begin : g_chan
      localparam logic [IDX_W-1:0] CFG_IDX = (g < N_DIN) ? I_DIN_CFG : I_VIN_CFG;
      if (g < N_DIN) begin : g_direct
         assign chan_raw[g] = din_raw[g];
      end else begin : g_virtual
         assign chan_raw[g] = sig_at(out_sig,
            code_at(st_reg.cfg, I_VIN_SRC, g - N_DIN));
      end
      iosc_chan u_chan (
         .aclk       (aclk),
         .aresetn    (aresetn),
         .tick       (tick),
         .invert     (st_reg.cfg[CFG_IDX][CFG_INV_BIT]),
         .dead_ms    (st_reg.cfg[CFG_IDX][CFG_DEAD_LSB +: DEAD_W]),
         .oneshot_en (st_reg.cfg[CFG_IDX][CFG_ONESHOT_BIT]),
         .raw        (chan_raw[g]),
         .on         (chan_on[g])
      );
   end

   always_comb begin
      logic [IDX_W-1:0]  widx;
      logic [IDX_W-1:0]  ridx;
      logic [DATA_W-1:0] word;
      logic [DATA_W-1:0] rword;
      logic              rhit;
      logic [N_SIG-1:0]  fvec;

      st_next = st_reg;
      widx    = st_reg.awaddr[ADDR_W-1:2];
      ridx    = axil_req.araddr[ADDR_W-1:2];
      word    = '0;
      rword   = '0;
      rhit    = 1'b1;
      fvec    = '0;

      // Write address and data are taken in either order
      if (axil_req.awvalid && st_reg.rsp.awready) begin
         st_next.aw_held = 1'b1;
         st_next.awaddr  = axil_req.awaddr;
      end
      if (axil_req.wvalid && st_reg.rsp.wready) begin
         st_next.w_held = 1'b1;
         st_next.wdata  = axil_req.wdata;
         st_next.wstrb  = axil_req.wstrb;
      end
      if (st_reg.rsp.bvalid && axil_req.bready) begin
         st_next.rsp.bvalid = 1'b0;
      end

      if (st_reg.aw_held && st_reg.w_held && !st_reg.rsp.bvalid) begin
         st_next.aw_held    = 1'b0;
         st_next.w_held     = 1'b0;
         st_next.rsp.bvalid = 1'b1;
         st_next.rsp.bresp  = RESP_DECERR;
         if (widx < IDX_W'(N_CFG)) begin
            word = st_reg.cfg[widx];
            for (int b = 0; b < STRB_W; b++) begin
               if (st_reg.wstrb[b]) begin
                  word[b*LANE_W +: LANE_W] = st_reg.wdata[b*LANE_W +: LANE_W];
               end
            end
            if (widx == I_DIN_CFG || widx == I_VIN_CFG) begin
               word = word & CFG_MASK;
               word[CFG_DEAD_LSB +: DEAD_W] =
                  clamp_dead(word[CFG_DEAD_LSB +: DEAD_W]);
            end else begin
               word = word & FUNC_MASK;
            end
            st_next.cfg[widx] = word;
            st_next.rsp.bresp = RESP_OKAY;
         end
      end
      st_next.rsp.awready = !st_next.aw_held && !st_next.rsp.bvalid;
      st_next.rsp.wready  = !st_next.w_held && !st_next.rsp.bvalid;

      // Read path: one read at a time, answered the cycle after arrival
      if (st_reg.rsp.rvalid && axil_req.rready) begin
         st_next.rsp.rvalid = 1'b0;
      end
      if (axil_req.arvalid && st_reg.rsp.arready) begin
         if (ridx < IDX_W'(N_CFG)) begin
            rword = st_reg.cfg[ridx];
         end else if (ridx == I_STATUS) begin
            rword[ST_DIN_LSB +: N_DIN]   = chan_on[N_DIN-1:0];
            rword[ST_VIN_LSB +: N_VIN]   = chan_on[N_CHAN-1:N_DIN];
            rword[ST_DOUT_LSB +: N_DOUT] = st_reg.dout;
            rword[ST_RAW_LSB +: N_DIN]   = din_raw;
         end else if (ridx == I_INFUNC_LO) begin
            rword = st_reg.in_func[DATA_W-1:0];
         end else if (ridx == I_INFUNC_HI) begin
            rword = st_reg.in_func[N_SIG-1:DATA_W];
         end else begin
            rhit = 1'b0;
         end
         st_next.rsp.rvalid = 1'b1;
         st_next.rsp.rdata  = rword;
         st_next.rsp.rresp  = rhit ? RESP_OKAY : RESP_DECERR;
      end
      st_next.rsp.arready = !st_next.rsp.rvalid;

      // Conditioned inputs drive their main functions; direct inputs also drive their composite functions
      for (int i = 0; i < N_DIN; i++) begin
         if (chan_on[i]) begin
            fvec[code_at(st_reg.cfg, I_DIN_FUNC0, i)] = 1'b1;
            fvec[code_at(st_reg.cfg, I_DIN_COMP0, i)] = 1'b1;
         end
      end
      for (int j = 0; j < N_VIN; j++) begin
         if (chan_on[N_DIN + j]) begin
            fvec[code_at(st_reg.cfg, I_VIN_FUNC, j)] = 1'b1;
         end
      end
      // Code 0 means not used and must never reach the controller
      fvec[IN_NOT_USED[CODE_W-1:0]] = 1'b0;
      st_next.in_func = fvec;

      for (int k = 0; k < N_DOUT; k++) begin
         st_next.dout[k] = sig_at(out_sig, code_at(st_reg.cfg, I_DOUT_FUNC0, k));
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_reg             <= '0;
         st_reg.cfg         <= CFG_RST;
         st_reg.rsp.awready <= 1'b1;
         st_reg.rsp.wready  <= 1'b1;
         st_reg.rsp.arready <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   assign axil_rsp = st_reg.rsp;
   assign in_func  = st_reg.in_func;
   assign dout     = st_reg.dout;

endmodule

// [logic/iosc_pkg.sv]
package iosc_pkg;

   // Clock and timing base
   localparam int CLK_PERIOD_NS = 20;
   localparam int NS_PER_US     = 1000;
   localparam int US_PER_MS     = 1000;
   localparam int TICK_NS       = 1000;
   localparam int TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
   localparam int TICKS_PER_MS  = US_PER_MS * NS_PER_US / TICK_NS;
   localparam int DEAD_MAX_MS   = 250;
   localparam int ONESHOT_US    = 250;
   localparam int ONESHOT_TICKS = ONESHOT_US * NS_PER_US / TICK_NS;

   // Sizes
   localparam int N_DIN    = 8;
   localparam int N_VIN    = 4;
   localparam int N_CHAN   = N_DIN + N_VIN;
   localparam int N_DOUT   = 8;
   localparam int CODE_W   = 6;
   localparam int N_SIG    = 64;
   localparam int DEAD_W   = 8;
   localparam int DT_W     = 18;
   localparam int OS_W     = 9;
   localparam int TICK_W   = 8;
   localparam int ADDR_W   = 8;
   localparam int DATA_W   = 32;
   localparam int STRB_W   = DATA_W / 8;
   localparam int LANE_W   = 8;

   // Input function codes
   localparam logic [7:0] IN_NOT_USED                  = 8'h00;
   localparam logic [7:0] IN_CURRENT_OFF              = 8'h01;
   localparam logic [7:0] IN_CURRENT_OFF_BRAKE_RELEASE = 8'h02;
   localparam logic [7:0] IN_STOP                      = 8'h10;
   localparam logic [7:0] IN_PAUSE                     = 8'h11;
   localparam logic [7:0] IN_ALARM_RESET_REQ           = 8'h18;
   localparam logic [7:0] IN_DRIVE_EXCITATION_RESTORE  = 8'h1A;
   localparam logic [7:0] IN_OPERATOR_INTERLOCK        = 8'h1C;
   localparam logic [7:0] IN_PROGRAM_INPUT0            = 8'h30;
   localparam logic [7:0] IN_PROGRAM_INPUT1            = 8'h31;

   // Output signal codes; code 0 never asserts
   localparam logic [7:0] OUT_ALWAYS_LOW_SOURCE        = 8'h00;
   localparam logic [7:0] OUT_READY                    = 8'h01;
   localparam logic [7:0] OUT_MOVE                     = 8'h02;
   localparam logic [7:0] OUT_DRIVE_EXCITATION_MONITOR = 8'h03;
   localparam logic [7:0] OUT_ALARM_OUT_ACTIVE_LOW     = 8'h04;
   localparam logic [7:0] OUT_PAUSE_BUSY_FLAG          = 8'h05;
   localparam logic [7:0] OUT_PROGRAM_RUNNING          = 8'h06;
   localparam logic [7:0] OUT_PROGRAM_OUTPUT0          = 8'h07;
   localparam logic [7:0] OUT_PROGRAM_OUTPUT1          = 8'h08;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFS_DIN_FUNC0  = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_DIN_FUNC1  = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_DIN_COMP0  = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_DIN_COMP1  = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_DIN_CFG    = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_VIN_FUNC   = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_VIN_SRC    = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_VIN_CFG    = 8'h1C;
   localparam logic [ADDR_W-1:0] OFS_DOUT_FUNC0 = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_DOUT_FUNC1 = 8'h24;
   localparam logic [ADDR_W-1:0] OFS_STATUS     = 8'h28;
   localparam logic [ADDR_W-1:0] OFS_INFUNC_LO  = 8'h2C;
   localparam logic [ADDR_W-1:0] OFS_INFUNC_HI  = 8'h30;
   localparam int                N_CFG          = 10;

   // Config word fields
   localparam int CFG_DEAD_LSB    = 0;
   localparam int CFG_INV_BIT     = 8;
   localparam int CFG_ONESHOT_BIT = 9;
   localparam logic [DATA_W-1:0] FUNC_MASK = 32'h3F3F3F3F;
   localparam logic [DATA_W-1:0] CFG_MASK  = 32'h000003FF;

   // Status word fields
   localparam int ST_DIN_LSB  = 0;
   localparam int ST_VIN_LSB  = 8;
   localparam int ST_DOUT_LSB = 16;
   localparam int ST_RAW_LSB  = 24;

   // Reset values
   localparam logic [DATA_W-1:0] RST_DIN_FUNC0 = {IN_ALARM_RESET_REQ,
      IN_DRIVE_EXCITATION_RESTORE, IN_CURRENT_OFF_BRAKE_RELEASE, IN_STOP};
   localparam logic [DATA_W-1:0] RST_DIN_FUNC1 = {IN_PROGRAM_INPUT1,
      IN_PROGRAM_INPUT0, IN_NOT_USED, IN_PAUSE};
   localparam logic [DATA_W-1:0] RST_NONE      = 32'h00000000;
   localparam logic [DATA_W-1:0] RST_DOUT_FUNC0 = {OUT_ALARM_OUT_ACTIVE_LOW,
      OUT_DRIVE_EXCITATION_MONITOR, OUT_MOVE, OUT_READY};
   localparam logic [DATA_W-1:0] RST_DOUT_FUNC1 = {OUT_PROGRAM_OUTPUT1,
      OUT_PROGRAM_OUTPUT0, OUT_PROGRAM_RUNNING, OUT_PAUSE_BUSY_FLAG};

   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_DECERR = 2'b11;

   typedef struct packed {
      logic              awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic              wvalid;
      logic [DATA_W-1:0] wdata;
      logic [STRB_W-1:0] wstrb;
      logic              bready;
      logic              arvalid;
      logic [ADDR_W-1:0] araddr;
      logic              rready;
   } iosc_axil_req_t;

   typedef struct packed {
      logic              awready;
      logic              wready;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              arready;
      logic              rvalid;
      logic [DATA_W-1:0] rdata;
      logic [1:0]        rresp;
   } iosc_axil_rsp_t;

endpackage

// [logic/iosc_tick.sv]
`timescale 1ns/1ps
module iosc_tick import iosc_pkg::*; #(
   parameter int CYC = TICK_CYC
) (
   // Clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // Tick out
   output logic      tick
);

   typedef struct packed {
      logic [TICK_W-1:0] cnt;
      logic              tick;
   } iosc_tick_state_t;

   iosc_tick_state_t st_reg;
   iosc_tick_state_t st_next;

   always_comb begin
      st_next      = st_reg;
      st_next.tick = 1'b0;
      if (st_reg.cnt == TICK_W'(CYC - 1)) begin
         st_next.cnt  = '0;
         st_next.tick = 1'b1;
      end else begin
         st_next.cnt = st_reg.cnt + 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign tick = st_reg.tick;

endmodule

// [logic/iosc_chan.sv]
`timescale 1ns/1ps
module iosc_chan import iosc_pkg::*; (
   // Clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // Time base
   input  wire logic              tick,
   // Settings
   input  wire logic              invert,
   input  wire logic [DEAD_W-1:0] dead_ms,
   input  wire logic              oneshot_en,
   // Signal
   input  wire logic              raw,
   output logic                   on
);

   typedef struct packed {
      logic [DT_W-1:0] dt_cnt;
      logic [OS_W-1:0] os_cnt;
      logic            on;
      logic            fired;
   } iosc_chan_state_t;

   iosc_chan_state_t st_reg;
   iosc_chan_state_t st_next;
   logic             lvl;
   logic [DT_W-1:0]  dead_ticks;

   assign lvl        = raw ^ invert;
   assign dead_ticks = DT_W'(dead_ms) * DT_W'(TICKS_PER_MS);

   always_comb begin
      st_next = st_reg;
      if (!lvl) begin
         // Any release restarts both timers
         st_next = '0;
      end else if (!st_reg.on && !st_reg.fired) begin
         // ON only after the level outlasts the dead time
         if (st_reg.dt_cnt >= dead_ticks) begin
            st_next.on     = 1'b1;
            st_next.os_cnt = '0;
         end else if (tick) begin
            st_next.dt_cnt = st_reg.dt_cnt + 1'b1;
         end
      end else if (st_reg.on && oneshot_en) begin
         // Pulse ends after the fixed width, held off until release
         if (st_reg.os_cnt >= OS_W'(ONESHOT_TICKS)) begin
            st_next.on    = 1'b0;
            st_next.fired = 1'b1;
         end else if (tick) begin
            st_next.os_cnt = st_reg.os_cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign on = st_reg.on;

endmodule

// [bench/iosc_top_assertions.sv]
`timescale 1ns/1ps
module iosc_top_assertions import iosc_pkg::*; (
   // Clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // Register bus
   input  wire iosc_axil_req_t    axil_req,
   input  wire iosc_axil_rsp_t    axil_rsp,
   // Terminals and signal lists
   input  wire logic [N_DIN-1:0]  din_raw,
   input  wire logic [N_SIG-1:0]  out_sig,
   input  wire logic [N_SIG-1:0]  in_func,
   input  wire logic [N_DOUT-1:0] dout
);
   logic       touched_reg;
   logic [1:0] run_reg;

   // Reset mapping is only trusted until the first write is offered
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         touched_reg <= 1'b0;
         run_reg     <= 2'h0;
      end else begin
         touched_reg <= touched_reg | axil_req.awvalid;
         run_reg     <= (run_reg == 2'h3) ? run_reg : run_reg + 2'h1;
      end
   end

   function automatic logic [N_SIG-1:0] dflt_func(input logic [N_DIN-1:0] d);
      logic [N_SIG-1:0] f;
      f                              = '0;
      f[IN_STOP]                     = d[0];
      f[IN_CURRENT_OFF_BRAKE_RELEASE] = d[1];
      f[IN_DRIVE_EXCITATION_RESTORE] = d[2];
      f[IN_ALARM_RESET_REQ]          = d[3];
      f[IN_PAUSE]                    = d[4];
      f[IN_PROGRAM_INPUT0]           = d[6];
      f[IN_PROGRAM_INPUT1]           = d[7];
      return f;
   endfunction

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence wr_both;
      axil_req.awvalid && axil_rsp.awready && axil_req.wvalid && axil_rsp.wready;
   endsequence
   sequence din_steady;
      $stable(din_raw) [*3];
   endsequence

   AST_RST_OUT: assert property ($rose(aresetn) |-> dout == '0 && in_func == '0
      && !axil_rsp.bvalid && !axil_rsp.rvalid) else $error("outputs not cleared by reset");
   AST_NOT_USED: assert property (in_func[0] == 1'b0)
      else $error("unused function code asserted");
   AST_DIN_DEFAULT: assert property (din_steady ##0 (run_reg == 2'h3 && !touched_reg)
      |-> in_func == dflt_func(din_raw)) else $error("default input mapping wrong");
   AST_DOUT_DEFAULT: assert property (run_reg == 2'h3 && !touched_reg
      |-> dout == $past(out_sig[8:1])) else $error("default output mapping wrong");
   AST_WR_ANSWER: assert property (wr_both |-> ##[1:2] axil_rsp.bvalid)
      else $error("write response missing");
   AST_WR_DONE: assert property (axil_rsp.bvalid && axil_req.bready |=> !axil_rsp.bvalid)
      else $error("write response not retired");
   AST_WR_BLOCK: assert property (axil_rsp.bvalid |-> !axil_rsp.awready && !axil_rsp.wready)
      else $error("write accepted while response pending");
   AST_RD_ANSWER: assert property (axil_req.arvalid && axil_rsp.arready |=> axil_rsp.rvalid)
      else $error("read data missing");
   AST_RD_DONE: assert property (axil_rsp.rvalid && axil_req.rready |=> !axil_rsp.rvalid)
      else $error("read data not retired");
   AST_RD_BLOCK: assert property (axil_rsp.rvalid |-> !axil_rsp.arready)
      else $error("read accepted while data pending");
endmodule

bind iosc_top iosc_top_assertions iosc_top_assertions_i (
   .aclk(aclk), .aresetn(aresetn), .axil_req(axil_req), .axil_rsp(axil_rsp),
   .din_raw(din_raw), .out_sig(out_sig), .in_func(in_func), .dout(dout));

// [bench/iosc_switch_bank.sv]
`timescale 1ns/1ps
module iosc_switch_bank import iosc_pkg::*; (
   // Clock and reset
   input  wire logic             aclk,
   input  wire logic             aresetn,
   // Wanted contact levels and bounce enables
   input  wire logic [N_DIN-1:0] sw_level,
   input  wire logic [N_DIN-1:0] chatter,
   // Terminals
   output logic      [N_DIN-1:0] din_raw
);
   logic bounce_reg;

   always_ff @(posedge aclk) begin
      bounce_reg <= aresetn ? ~bounce_reg : 1'b0;
   end
   // Bouncing contacts flip every cycle, so no level outlasts a nonzero dead-time
   assign din_raw = sw_level ^ (chatter & {N_DIN{bounce_reg}});
endmodule

// [bench/iosc_top_tb.sv]
`timescale 1ns/1ps
module iosc_top_tb import iosc_pkg::*; ();
   logic                aclk     = 1'b0;
   logic                aresetn  = 1'b0;
   iosc_axil_req_t      req      = '0;
   iosc_axil_rsp_t      rsp;
   logic [N_DIN-1:0]    sw_level = '0;
   logic [N_DIN-1:0]    chatter  = '0;
   logic [N_DIN-1:0]    din_raw;
   logic [N_SIG-1:0]    out_sig  = '0;
   logic [N_SIG-1:0]    in_func;
   logic [N_DOUT-1:0]   dout;
   int                  err_count   = 0;
   int                  checks_done = 0;
   logic [DATA_W-1:0]   rst_tab [10] = '{RST_DIN_FUNC0, RST_DIN_FUNC1, RST_NONE, RST_NONE,
      RST_NONE, RST_NONE, RST_NONE, RST_NONE, RST_DOUT_FUNC0, RST_DOUT_FUNC1};

   always #10 aclk = ~aclk;

   iosc_switch_bank iosc_switch_bank_i (.aclk(aclk), .aresetn(aresetn),
      .sw_level(sw_level), .chatter(chatter), .din_raw(din_raw));
   iosc_top iosc_top_i (.aclk(aclk), .aresetn(aresetn), .axil_req(req), .axil_rsp(rsp),
      .din_raw(din_raw), .out_sig(out_sig), .in_func(in_func), .dout(dout));

   function automatic logic [N_SIG-1:0] exp_din(input logic [N_DIN-1:0] d);
      logic [N_SIG-1:0] f;
      f = '0;
      f[IN_STOP] = d[0];
      f[IN_CURRENT_OFF_BRAKE_RELEASE] = d[1];
      f[IN_DRIVE_EXCITATION_RESTORE] = d[2];
      f[IN_ALARM_RESET_REQ] = d[3];
      f[IN_PAUSE] = d[4];
      f[IN_PROGRAM_INPUT0] = d[6];
      f[IN_PROGRAM_INPUT1] = d[7];
      return f;
   endfunction

   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      checks_done++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", nm, e, g);
         err_count++;
      end
   endtask

   task automatic w(input int n);
      repeat (n) @(posedge aclk);
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Bounded waits: a silent slave shows up as a mismatch, not a hang
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      @(posedge aclk);
      req.awvalid <= 1'b1;
      req.awaddr  <= a;
      req.wvalid  <= 1'b1;
      req.wdata   <= d;
      req.wstrb   <= 4'hF;
      req.bready  <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (rsp.awready) req.awvalid <= 1'b0;
         if (rsp.wready) req.wvalid <= 1'b0;
         if (rsp.bvalid) break;
      end
      req.bready <= 1'b0;
      chk("write response", {1'b1, er}, {rsp.bvalid, rsp.bresp});
   endtask

   task automatic rchk(input logic [7:0] a, input logic [33:0] e);
      int n;
      @(posedge aclk);
      req.arvalid <= 1'b1;
      req.araddr  <= a;
      req.rready  <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (rsp.arready) req.arvalid <= 1'b0;
         if (rsp.rvalid) break;
      end
      req.rready <= 1'b0;
      chk($sformatf("register %h", a), {1'b1, e}, {rsp.rvalid, rsp.rresp, rsp.rdata});
   endtask

   task automatic pulse_chk(input string nm, input int bit_no);
      w(10);
      chk(nm, 1'b1, in_func[bit_no]);
      w(ONESHOT_TICKS * TICK_CYC - 500);
      chk(nm, 1'b1, in_func[bit_no]);
      w(1000);
      chk(nm, 1'b0, in_func[bit_no]);
   endtask

   initial begin
      void'($urandom(37));
      w(2);
      aresetn <= 1'b1;
      for (int i = 0; i < 10; i++) begin
         rchk(8'(i*4), {RESP_OKAY, rst_tab[i]});
      end
      rchk(8'h40, {RESP_DECERR, 32'h00000000});
      for (int i = 0; i < 8; i++) begin
         @(posedge aclk);
         sw_level <= (i == 0) ? 8'hFF : 8'($urandom());
         out_sig  <= {$urandom(), $urandom()};
         w(5);
         chk("dout", out_sig[8:1], dout);
         chk("in_func", exp_din(sw_level), in_func);
      end
      @(posedge aclk);
      sw_level <= 8'h00;
      wr(OFS_DIN_CFG, 32'h00000100, RESP_OKAY);
      w(5);
      chk("inverted inputs", exp_din(8'hFF), in_func);
      wr(OFS_DIN_CFG, 32'h000000FF, RESP_OKAY);
      rchk(OFS_DIN_CFG, {RESP_OKAY, 32'h000000FA});
      wr(OFS_VIN_CFG, 32'h000000FF, RESP_OKAY);
      rchk(OFS_VIN_CFG, {RESP_OKAY, 32'h000000FA});
      wr(OFS_VIN_CFG, 32'h00000000, RESP_OKAY);
      wr(OFS_DIN_CFG, 32'h00000001, RESP_OKAY);
      @(posedge aclk);
      sw_level <= 8'h01;
      chatter  <= 8'h01;
      w(300);
      chk("bouncing input", 1'b0, in_func[IN_STOP]);
      @(posedge aclk);
      chatter <= 8'h00;
      w(TICKS_PER_MS * TICK_CYC - 2000);
      chk("dead-time early", 1'b0, in_func[IN_STOP]);
      w(3000);
      chk("dead-time late", 1'b1, in_func[IN_STOP]);
      // Interlock stays unassigned, so one-shot is allowed here
      wr(OFS_DIN_CFG, 32'h00000300, RESP_OKAY);
      @(posedge aclk);
      sw_level <= 8'h00;
      pulse_chk("direct one-shot", IN_STOP);
      wr(OFS_DIN_CFG, 32'h00000000, RESP_OKAY);
      wr(OFS_DIN_COMP0, 32'h00000011, RESP_OKAY);
      @(posedge aclk);
      sw_level <= 8'h01;
      w(5);
      chk("composite", 2'b11, {in_func[IN_PAUSE], in_func[IN_STOP]});
      rchk(OFS_STATUS, {RESP_OKAY, 8'h01, out_sig[8:1], 8'h00, 8'h01});
      rchk(OFS_INFUNC_LO, {RESP_OKAY, (32'h1 << IN_STOP) | (32'h1 << IN_PAUSE)});
      rchk(OFS_INFUNC_HI, {RESP_OKAY, 32'h00000000});
      wr(OFS_VIN_FUNC, 32'h00000001, RESP_OKAY);
      wr(OFS_VIN_SRC, 32'h00000002, RESP_OKAY);
      @(posedge aclk);
      out_sig <= 64'h4;
      w(5);
      chk("virtual input", 1'b1, in_func[IN_CURRENT_OFF]);
      wr(OFS_VIN_CFG, 32'h00000100, RESP_OKAY);
      w(5);
      chk("virtual inverted", 1'b0, in_func[IN_CURRENT_OFF]);
      @(posedge aclk);
      out_sig <= 64'h0;
      w(5);
      chk("virtual inverted", 1'b1, in_func[IN_CURRENT_OFF]);
      wr(OFS_VIN_CFG, 32'h00000200, RESP_OKAY);
      @(posedge aclk);
      out_sig <= 64'h4;
      pulse_chk("virtual one-shot", IN_CURRENT_OFF);
      wr(OFS_DOUT_FUNC0, 32'h00000008, RESP_OKAY);
      @(posedge aclk);
      out_sig <= 64'h100;
      w(4);
      chk("dout remapped", 8'h81, dout);
      wr(8'h40, 32'h00000001, RESP_DECERR);
      wr(OFS_STATUS, 32'h00000000, RESP_DECERR);
      @(posedge aclk);
      aresetn <= 1'b0;
      w(2);
      aresetn <= 1'b1;
      rchk(OFS_DIN_CFG, {RESP_OKAY, RST_NONE});
      rchk(OFS_DOUT_FUNC0, {RESP_OKAY, RST_DOUT_FUNC0});
      finish_test();
   end

   initial begin
      w(95000);
      err_count++;
      finish_test();
   end
endmodule
